// [verilog/acc_defs.svh]
// constants for the converter control block: register offsets, fields, reset values, timing
// assumes a 32-bit apb slave, one aligned word per register, mclk at 50 mhz
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_OFF_CTRL1     12'h000
`define ACC_OFF_CTRL2     12'h004
`define ACC_OFF_RESHI     12'h008
`define ACC_OFF_RESLO     12'h00c
`define ACC_OFF_LATCH     12'h010
`define ACC_CTRL1_RST     8'h00
`define ACC_CTRL2_RST     8'h10
`define ACC_CTRL2_WMASK   8'h3e
`define ACC_CTRL2_FORCE   8'h10
`define ACC_BIT_START     7
`define ACC_BIT_LADDER    5
`define ACC_MODE_LSB      5
`define ACC_TIME_LSB      1
`define ACC_BIT_LATCH     0
`define ACC_CYC_039       16'd39
`define ACC_CYC_078       16'd78
`define ACC_CYC_156       16'd156
`define ACC_CYC_312       16'd312
`define ACC_CYC_624       16'd624
`define ACC_CYC_1248      16'd1248
`endif

// [verilog/acc_pkg.sv]
// types for the converter control block
// assumes acc_defs.svh supplies the numeric constants
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_MODE_OFF    = 2'b00,
      ACC_MODE_SOFT   = 2'b01,
      ACC_MODE_RSVD   = 2'b10,
      ACC_MODE_REPEAT = 2'b11
   } acc_mode_t;
   typedef enum logic [1:0] {
      ACC_ST_IDLE = 2'b00,
      ACC_ST_CONV = 2'b01,
      ACC_ST_DONE = 2'b10
   } acc_state_t;
   typedef struct packed {
      logic [3:0] channelSelect;
      logic       analogInputDisable;
      logic       ladderConnect;
      logic       busy;
   } acc_analog_t;
endpackage

// [verilog/acc_rst_sync.sv]
// reset release synchroniser
// assumes rst_n is asynchronous to mclk
`timescale 1ns/10ps
module acc_rst_sync (
   input  wire logic mclk,
   input  wire logic rst_n,
   output logic      rstSync_n
);
   logic stage1_n;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_n  <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         stage1_n  <= 1'b1;
         rstSync_n <= stage1_n;
      end
   end
endmodule

// [verilog/acc_timer.sv]
// conversion timer: loads a cycle count, counts down, pulses when done
// assumes load and abort come from logic on mclk
`timescale 1ns/10ps
`include "acc_defs.svh"
module acc_timer #(
   parameter int W = 16
) (
   input  wire logic         mclk,
   input  wire logic         rstSync_n,
   input  wire logic         load,
   input  wire logic         abort,
   input  wire logic [2:0]   timeCode,
   output logic              expired
);
   logic [W-1:0] count;
   logic         running;

   // reserved codes fall back to the shortest legal time
   function automatic logic [W-1:0] cycles(input logic [2:0] code);
      case (code)
         3'h2:    cycles = W'(`ACC_CYC_078);
         3'h3:    cycles = W'(`ACC_CYC_156);
         3'h4:    cycles = W'(`ACC_CYC_312);
         3'h5:    cycles = W'(`ACC_CYC_624);
         3'h6:    cycles = W'(`ACC_CYC_1248);
         default: cycles = W'(`ACC_CYC_039);
      endcase
   endfunction

   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         count   <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (abort) begin
            running <= 1'b0;
         end else if (load) begin
            count   <= cycles(timeCode) - W'(1);
            running <= 1'b1;
         end else if (running) begin
            if (count == W'(1)) begin
               running <= 1'b0;
               expired <= 1'b1;
            end else begin
               count <= count - W'(1);
            end
         end
      end
   end
endmodule

// [verilog/acc_conversion_control.sv]
// converter control top: apb register file, start logic, result storage, standby handling
// assumes an apb master on mclk and a sar core returning its 10-bit code on sampleCode
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "acc_defs.svh"
module acc_conversion_control (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        standbyReq,
   input  wire logic        irqAccept,
   input  wire logic [9:0]  sampleCode,
   output logic             conversionDoneIrq,
   output logic             conversionIrqLatch,
   output acc_pkg::acc_analog_t analogCtl
);
   logic                rstSync_n;
   logic [7:0]          adcControlOne;
   logic [7:0]          adcControlTwo;
   logic [9:0]          result;
   logic                endOfConversionFlag;
   logic                conversionBusyFlag;
   acc_pkg::acc_state_t state;
   logic                timerLoad;
   logic                timerExpired;
   logic                standbySync1;
   logic                standbySync2;
   logic                apbWrite;
   logic                apbRead;
   logic                abortConv;
   acc_pkg::acc_mode_t  mode;
   logic                startReq;
   logic                repeatGo;
   logic [31:0]         next_prdata;

   acc_rst_sync u_rst (
      .mclk      (mclk),
      .rstSync_n (rstSync_n),
      .rst_n     (rst_n)
   );

   acc_timer #(.W(16)) u_timer (
      .mclk      (mclk),
      .rstSync_n (rstSync_n),
      .load      (timerLoad),
      .abort     (abortConv),
      .timeCode  (adcControlTwo[`ACC_TIME_LSB +: 3]),
      .expired   (timerExpired)
   );

   // standby request comes from the power manager on another timing path
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         standbySync1 <= 1'b0;
         standbySync2 <= 1'b0;
      end else begin
         standbySync1 <= standbyReq;
         standbySync2 <= standbySync1;
      end
   end

   // writes and clearing reads act only at the completing edge, so a re-sampled
   // start bit cannot overwrite the automatic clear
   assign apbWrite = psel && penable && pready && pwrite;
   assign apbRead  = psel && penable && pready && !pwrite;
   assign mode     = acc_pkg::acc_mode_t'(adcControlOne[`ACC_MODE_LSB +: 2]);
   // a mode write to disabled stops repeat at once, nothing stored
   assign abortConv = standbySync2 ||
                      (apbWrite && paddr == `ACC_OFF_CTRL1 &&
                       pwdata[`ACC_MODE_LSB +: 2] == 2'b00);
   // start bit only acts in software start or repeat mode; reserved mode ignores it
   assign startReq = adcControlOne[`ACC_BIT_START] &&
                     (mode == acc_pkg::ACC_MODE_SOFT ||
                      mode == acc_pkg::ACC_MODE_REPEAT);
   assign repeatGo = timerExpired && mode == acc_pkg::ACC_MODE_REPEAT;
   assign timerLoad = !abortConv && ((state != acc_pkg::ACC_ST_CONV && startReq) || repeatGo);

   // control one: standby forces the reset value and blocks writes
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         adcControlOne <= `ACC_CTRL1_RST;
      end else if (standbySync2) begin
         adcControlOne <= `ACC_CTRL1_RST;
      end else if (apbWrite && paddr == `ACC_OFF_CTRL1) begin
         adcControlOne <= pwdata[7:0];
      end else if (timerLoad) begin
         adcControlOne[`ACC_BIT_START] <= 1'b0;
      end
   end

   // control two: bit 4 reads one, bits 0, 6 and 7 are fixed
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         adcControlTwo <= `ACC_CTRL2_RST;
      end else if (standbySync2) begin
         adcControlTwo <= `ACC_CTRL2_RST;
      end else if (apbWrite && paddr == `ACC_OFF_CTRL2) begin
         adcControlTwo <= (pwdata[7:0] & `ACC_CTRL2_WMASK) | `ACC_CTRL2_FORCE;
      end
   end

   // sequencer
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state <= acc_pkg::ACC_ST_IDLE;
      end else begin
         case (state)
            acc_pkg::ACC_ST_IDLE: begin
               if (timerLoad) begin
                  state <= acc_pkg::ACC_ST_CONV;
               end
            end
            acc_pkg::ACC_ST_CONV: begin
               if (abortConv) begin
                  state <= acc_pkg::ACC_ST_IDLE;
               end else if (timerExpired) begin
                  state <= repeatGo ? acc_pkg::ACC_ST_CONV : acc_pkg::ACC_ST_DONE;
               end
            end
            acc_pkg::ACC_ST_DONE: begin
               state <= timerLoad ? acc_pkg::ACC_ST_CONV : acc_pkg::ACC_ST_IDLE;
            end
            default: state <= acc_pkg::ACC_ST_IDLE;
         endcase
      end
   end

   // busy flag
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         conversionBusyFlag <= 1'b0;
      end else if (abortConv) begin
         conversionBusyFlag <= 1'b0;
      end else if (timerLoad) begin
         conversionBusyFlag <= 1'b1;
      end else if (timerExpired) begin
         conversionBusyFlag <= 1'b0;
      end
   end

   // result holds through a restart until the new conversion ends
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         result <= '0;
      end else if (standbySync2) begin
         result <= '0;
      end else if (timerExpired && !abortConv) begin
         result <= sampleCode;
      end
   end

   // end flag: completion wins over a same-cycle clearing read
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         endOfConversionFlag <= 1'b0;
      end else if (timerExpired && !abortConv) begin
         endOfConversionFlag <= 1'b1;
      end else if (standbySync2 || timerLoad) begin
         endOfConversionFlag <= 1'b0;
      end else if (apbRead && paddr == `ACC_OFF_RESHI) begin
         endOfConversionFlag <= 1'b0;
      end
   end

   // done pulse and interrupt latch; acceptance of a lower level may clear the latch unserviced
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         conversionDoneIrq  <= 1'b0;
         conversionIrqLatch <= 1'b0;
      end else begin
         conversionDoneIrq <= timerExpired && !abortConv;
         if (timerExpired && !abortConv) begin
            conversionIrqLatch <= 1'b1;
         end else if (irqAccept) begin
            conversionIrqLatch <= 1'b0;
         end else if (apbWrite && paddr == `ACC_OFF_LATCH && !pwdata[`ACC_BIT_LATCH]) begin
            conversionIrqLatch <= 1'b0;
         end
      end
   end

   // analog side controls; ladder off in standby
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         analogCtl <= '0;
      end else begin
         analogCtl.channelSelect      <= adcControlOne[3:0];
         analogCtl.analogInputDisable <= adcControlOne[4];
         analogCtl.busy               <= conversionBusyFlag && !abortConv;
         analogCtl.ladderConnect      <= !standbySync2 &&
                                         (adcControlTwo[`ACC_BIT_LADDER] || conversionBusyFlag);
      end
   end

   // apb read mux
   always_comb begin
      next_prdata = '0;
      case (paddr)
         `ACC_OFF_CTRL1: next_prdata[7:0] = adcControlOne;
         `ACC_OFF_CTRL2: next_prdata[7:0] = adcControlTwo;
         `ACC_OFF_RESHI: next_prdata[7:0] = result[9:2];
         `ACC_OFF_RESLO: next_prdata[7:0] = {result[1:0], endOfConversionFlag,
                                             conversionBusyFlag, 4'h0};
         `ACC_OFF_LATCH: next_prdata[0]   = conversionIrqLatch;
         default:        next_prdata      = '0;
      endcase
   end

   // one wait state: pready rises the cycle after the access phase begins
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready &&
                    !(paddr == `ACC_OFF_CTRL1 || paddr == `ACC_OFF_CTRL2 ||
                      paddr == `ACC_OFF_RESHI || paddr == `ACC_OFF_RESLO ||
                      paddr == `ACC_OFF_LATCH);
         prdata  <= (psel && penable && !pready && !pwrite) ? next_prdata : '0;
      end
   end
endmodule

// [bench/acc_conversion_control_monitor.sv]
// checker for the converter control top: handshake, completion and standby relations
// assumes it is bound to acc_conversion_control and sees only its ports
`timescale 1ns/10ps
module acc_conversion_control_monitor (
   input wire logic                 mclk,
   input wire logic                 rst_n,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 standbyReq,
   input wire logic                 irqAccept,
   input wire logic [9:0]           sampleCode,
   input wire logic                 conversionDoneIrq,
   input wire logic                 conversionIrqLatch,
   input wire acc_pkg::acc_analog_t analogCtl
);
   logic [15:0] runLen;
   logic        prevBusy;
   logic [2:0]  sbHist;
   // run length saturates so long repeat runs never wrap into a false short count
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         runLen   <= 16'h0000;
         prevBusy <= 1'b0;
         sbHist   <= 3'h0;
      end else begin
         prevBusy <= analogCtl.busy;
         sbHist   <= {sbHist[1:0], standbyReq};
         if (analogCtl.busy && !prevBusy)
            runLen <= 16'h0001;
         else if (analogCtl.busy && runLen != 16'hffff)
            runLen <= runLen + 16'h0001;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_start_sets_busy: assert property (psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[7] &&
      pwdata[6:5] == 2'b01 && sbHist == 3'h0 && !standbyReq |-> ##[1:3] analogCtl.busy)
      else $error("start did not raise busy");
   a_done_one_pulse: assert property (conversionDoneIrq |=> !conversionDoneIrq)
      else $error("done request longer than one cycle");
   a_done_sets_latch: assert property (conversionDoneIrq |-> ##[0:1] conversionIrqLatch)
      else $error("done request without latch");
   a_done_min_time: assert property (conversionDoneIrq |-> runLen >= 16'd38)
      else $error("conversion finished too early");
   a_pready_one: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_access_answer: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   a_unmapped_err: assert property (psel && penable && pready && paddr > 12'h010 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_standby_quiet: assert property (standbyReq [*4] |-> !analogCtl.busy && !analogCtl.ladderConnect)
      else $error("converter active in standby");
   a_standby_ctrl: assert property (standbyReq [*4] ##0 (psel && penable && pready && !pwrite && paddr == 12'h000)
      |-> prdata == 32'h0)
      else $error("control one not reset in standby");
   c_done: cover property (conversionDoneIrq);
   c_err: cover property (pslverr);
   c_standby: cover property (standbyReq [*4]);
endmodule
bind acc_conversion_control acc_conversion_control_monitor u_mon (.*);

// [bench/acc_conversion_control_bench.sv]
// self-checking bench for the converter control top: apb reads queued and compared by a watcher
// assumes the bench alone drives every port; the sar code comes from a bench lfsr
`timescale 1ns/10ps
module acc_conversion_control_bench;
   logic mclk = 1'b0;
   logic rst_n, psel, penable, pwrite, pready, pslverr, standbyReq, irqAccept;
   logic conversionDoneIrq, conversionIrqLatch;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0]  sampleCode, code;
   logic [15:0] lf = 16'h0042;
   logic [64:0] expQ[$];
   acc_pkg::acc_analog_t analogCtl;
   int n_mismatch = 0, num_checks = 0, doneCnt = 0, cnt, d0;
   localparam logic [31:0] ALL = 32'hffffffff;
   always #10 mclk = ~mclk;
   acc_conversion_control dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .standbyReq(standbyReq), .irqAccept(irqAccept), .sampleCode(sampleCode),
      .conversionDoneIrq(conversionDoneIrq), .conversionIrqLatch(conversionIrqLatch), .analogCtl(analogCtl));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict;
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic err = 1'b0);
      expQ.push_back({err, m, e});
      apb(1'b0, a, 32'h0);
   endtask
   // wait on the falling edge so the done counter of the rising edge has settled
   task automatic wait_done;
      d0 = doneCnt;
      cnt = 0;
      while (doneCnt == d0 && cnt < 3000) begin
         @(negedge mclk);
         cnt++;
      end
      @(posedge mclk);
   endtask
   task automatic start(input logic [2:0] t, input logic [7:0] c1);
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      sampleCode <= lf[9:0]; // held still through the run
      code = lf[9:0];
      apb(1'b1, 12'h004, {27'h0, 1'b1, t, 1'b0});
      apb(1'b1, 12'h000, {24'h0, c1});
   endtask
   always @(posedge mclk) begin
      if (conversionDoneIrq === 1'b1)
         doneCnt++;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check("prdata", prdata & expQ[0][63:32], expQ[0][31:0]);
         check("pslverr", 32'(pslverr), 32'(expQ[0][64]));
         void'(expQ.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {rst_n, psel, penable, pwrite, standbyReq, irqAccept} = 6'h0;
      {paddr, pwdata, sampleCode} = 54'h0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(12'h000, 32'h0, ALL);
      rd(12'h004, 32'h10, ALL);
      rd(12'h014, 32'h0, ALL, 1'b1);
      apb(1'b1, 12'h004, 32'hd8);
      rd(12'h004, 32'h18, ALL);
      for (int i = 0; i < 4; i++) begin
         start(3'(i + (i != 0)), {3'b101, i[0], 4'h3});
         wait_done();
         check("cycles", 32'(cnt >= (39 << i) - 4 && cnt <= (39 << i) + 4), 32'h1);
         check("channel", 32'(analogCtl.channelSelect), 32'h3);
         check("inputoff", 32'(analogCtl.analogInputDisable), 32'(i[0]));
         rd(12'h000, 32'({3'b001, i[0], 4'h3}), ALL);
         rd(12'h00c, {code[1:0], 2'b10, 4'h0}, 32'hf0);
         rd(12'h008, 32'(code[9:2]), ALL);
         rd(12'h00c, {code[1:0], 2'b00, 4'h0}, 32'hf0);
         rd(12'h010, 32'h1, ALL);
         apb(1'b1, 12'h010, 32'h0);
         rd(12'h010, 32'h0, ALL);
      end
      // reserved time code runs the shortest time
      start(3'h7, 8'ha3);
      wait_done();
      check("reserved time", 32'(cnt >= 35 && cnt <= 43), 32'h1);
      start(3'h0, 8'ha3);
      wait_done();
      d0 = code;
      start(3'h0, 8'ha3);
      rd(12'h00c, {d0[1:0], 2'b01, 4'h0}, 32'hf0);
      rd(12'h008, 32'(d0[9:2]), ALL);
      check("active", 32'({analogCtl.busy, analogCtl.ladderConnect}), 32'h3);
      wait_done();
      rd(12'h008, 32'(code[9:2]), ALL);
      start(3'h0, 8'he3);
      wait_done();
      wait_done();
      check("repeat", 32'(cnt < 60), 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      d0 = doneCnt;
      repeat (100) @(posedge mclk);
      check("stopped", doneCnt - d0 + 32'(analogCtl.busy), 32'h0);
      irqAccept <= 1'b1;
      @(posedge mclk);
      irqAccept <= 1'b0;
      repeat (2) @(posedge mclk);
      check("latch", 32'(conversionIrqLatch), 32'h0);
      rd(12'h010, 32'h0, ALL);
      rd(12'h00c, 32'h20, 32'h30);
      start(3'h6, 8'ha3);
      repeat (10) @(posedge mclk);
      standbyReq <= 1'b1;
      repeat (5) @(posedge mclk);
      check("abort", 32'({analogCtl.busy, analogCtl.ladderConnect}), 32'h0);
      apb(1'b1, 12'h000, 32'ha3);
      rd(12'h000, 32'h0, ALL);
      rd(12'h004, 32'h10, ALL);
      rd(12'h008, 32'h0, ALL);
      standbyReq <= 1'b0;
      d0 = doneCnt;
      repeat (1400) @(posedge mclk);
      check("resume", doneCnt - d0 + 32'(analogCtl.busy), 32'h0);
      // reserved mode ignores the start bit
      apb(1'b1, 12'h000, 32'hc3);
      d0 = doneCnt;
      repeat (60) @(posedge mclk);
      check("reserved mode", doneCnt - d0 + 32'(analogCtl.busy), 32'h0);
      print_verdict();
   end
endmodule
